// [rtl/sbl_pkg.sv]
// Constants, types and helpers for the system bus lane and address engine.
// Assumes one 100 MHz clock; big-endian bit numbering, index 0 is the MSB.
package sbl_pkg;
  localparam logic [5:0] BURST_BYTES = 6'h20; // Four doublewords per burst
  localparam logic [1:0] PEND_MAX = 2'h2; // Outstanding address tenures
  localparam logic [4:0] ROW_SHIFT = 5'h0d; // SDRAM row move for multiplexing
  localparam int BANK_POS = 17; // First bank select address bit
  localparam logic [7:0] LANES_OFF = 8'hff; // Idle level of low-true lane pins
  localparam logic [2:0] DW_LOW_ZERO = 3'h0; // Low address pins on a doubleword
  localparam logic [1:0] SIZE_DW = 2'h3; // Size code of a doubleword access

  // Memory port width, value is log2 of its bytes
  typedef enum logic [1:0] {PORT8 = 2'h0, PORT16 = 2'h1, PORT32 = 2'h2,
                            PORT64 = 2'h3} sbl_port_t;
  // Who owns the addressed space
  typedef enum logic [1:0] {TGT_NONE = 2'h0, TGT_BANK = 2'h1, TGT_INTERNAL = 2'h2,
                            TGT_LOCAL = 2'h3} sbl_tgt_t;
  // Machine that serves a bank
  typedef enum logic [1:0] {MACH_GP = 2'h0, MACH_PROG = 2'h1,
                            MACH_SDRAM = 2'h2} sbl_mach_t;
  // Address tenure states
  typedef enum logic [2:0] {A_IDLE = 3'b001, A_DRIVE = 3'b010,
                            A_LAG = 3'b100} sbl_astate_t;
  // Data tenure states
  typedef enum logic [3:0] {D_IDLE = 4'b0001, D_BEAT = 4'b0010, D_GAP = 4'b0100,
                            D_ERR = 4'b1000} sbl_dstate_t;

  // One accepted address tenure
  typedef struct packed {
    logic [0:31] addr;
    logic [1:0] size;
    logic burst;
    logic write;
    sbl_port_t port;
    sbl_tgt_t tgt;
    sbl_mach_t mach;
    logic ext;
    logic early;
    logic err;
  } sbl_tenure_t;

  // Bytes carried by one beat of a port
  function automatic logic [3:0] sbl_port_bytes(input sbl_port_t p);
    return 4'h1 << p;
  endfunction
endpackage

// [rtl/sbl_lane_if.sv]
// Lane decode request and answer between the engine and its decoder.
// Assumes both ends share one clock; the decode is combinational.
`timescale 1ns/1ns
interface sbl_lane_if;
  logic [2:0] off; // Byte offset in the doubleword
  logic [3:0] nbytes; // Bytes in this beat
  sbl_pkg::sbl_port_t port; // Port width
  logic [0:7] lanes; // Lanes that carry data
  logic [2:0] shift; // Byte move toward lane 0
  modport dec (input off, input nbytes, input port, output lanes, output shift);
  modport user (output off, output nbytes, output port, input lanes, input shift);
endinterface

// [rtl/sbl_lane_decode.sv]
// Byte lane decoder: which lanes a beat uses and how far data moves.
// Assumes aligned beats that never cross a port boundary.
`timescale 1ns/1ns
module sbl_lane_decode (
  sbl_lane_if.dec lane
);
  logic [3:0] pb; // Port bytes
  logic [2:0] pos; // First lane used on the port
  logic [3:0] top; // One past the last lane

  // Narrow ports sit on the top lanes, so position wraps by port size
  always_comb begin
    pb = sbl_pkg::sbl_port_bytes(lane.port);
    pos = lane.off & 3'(pb - 4'h1);
    top = {1'b0, pos} + lane.nbytes;
    for (int i = 0; i < 8; i++) begin
      lane.lanes[i] = (4'(i) >= {1'b0, pos}) && (4'(i) < top);
    end
    lane.shift = lane.off - pos;
  end
endmodule

// [rtl/sbl_system_bus_lanes.sv]
// System bus lane and address engine of the memory controller.
// Assumes requests come from logic on mclk_i; pins are synchronised here.
`timescale 1ns/1ns
module sbl_system_bus_lanes (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic req_valid_i,
  input wire logic [0:31] req_addr_i,
  input wire logic [1:0] req_size_i,
  input wire logic req_burst_i,
  input wire logic req_write_i,
  input wire sbl_pkg::sbl_port_t req_port_i,
  input wire sbl_pkg::sbl_tgt_t req_tgt_i,
  input wire sbl_pkg::sbl_mach_t req_mach_i,
  input wire logic req_page_hit_i,
  input wire logic req_ext_i,
  input wire logic [0:63] req_wdata_i,
  input wire logic cfg_single_i,
  input wire logic cfg_eav_i,
  input wire logic cfg_no_ta_i,
  input wire logic bus_req_n_pin_i,
  input wire logic [0:63] data_pin_i,
  output logic req_ready_o,
  output logic [0:31] addr_o,
  output logic addr_oe_o,
  output logic [27:31] burst_low_address_o,
  output logic [0:63] data_o,
  output logic data_oe_o,
  output logic [0:7] lane_write_strobe_n_o,
  output logic [0:7] sdram_lane_mask_o,
  output logic [0:7] lane_byte_select_n_o,
  output logic partial_data_valid_strobe_n_o,
  output logic aack_n_o,
  output logic ta_n_o,
  output logic tea_n_o,
  output logic [0:1] sdram_bank_select_o,
  output logic bus_grant_n_o,
  output logic local_burst_o,
  output logic core_snoop_o,
  output logic rsp_beat_o,
  output logic [0:63] rsp_rdata_o
);
  import sbl_pkg::*;
  // Address side and queue state
  sbl_astate_t a_reg, a_next;
  sbl_tenure_t tn_reg, tn_next, q0_reg, q0_next, q1_reg, q1_next, new_tn, push_tn;
  logic [1:0] qcnt_reg, qcnt_next;
  logic lag_reg, lag_next;
  logic take, push, pop;
  // Data side state
  sbl_dstate_t d_reg, d_next;
  logic [0:31] cur_reg, cur_next;
  logic [5:0] rem_reg, rem_next;
  logic [3:0] pb, room, nb;
  // Pin synchronisers, first stage read only by second
  logic br_s1_reg, br_s2_reg;
  logic [0:63] din_s1_reg, din_s2_reg;
  // Registered outputs
  logic ready_reg, ready_next, aoe_reg, aoe_next, doe_reg, doe_next;
  logic [0:31] addr_reg, addr_next;
  logic [27:31] bla_reg, bla_next;
  logic [0:63] dout_reg, dout_next, rdata_reg, rdata_next;
  logic [0:7] we_reg, we_next, dqm_reg, dqm_next, bs_reg, bs_next;
  logic psd_reg, psd_next, aack_reg, aack_next, ta_reg, ta_next, tea_reg, tea_next;
  logic [0:1] bank_reg, bank_next;
  logic gnt_reg, gnt_next, lb_reg, lb_next, snp_reg, snp_next, beat_reg, beat_next;

  sbl_lane_if lane_bus ();
  sbl_lane_decode u_dec (.lane(lane_bus));

  // Beat size: bytes left, capped by what the port takes at this offset
  always_comb begin
    pb = sbl_port_bytes(q0_reg.port);
    room = pb - {1'b0, cur_reg[29:31] & 3'(pb - 4'h1)};
    nb = (rem_reg < {2'h0, room}) ? rem_reg[3:0] : room;
  end
  assign lane_bus.off = cur_reg[29:31];
  assign lane_bus.nbytes = nb;
  assign lane_bus.port = q0_reg.port;

  // Incoming request as a tenure
  always_comb begin
    // Doublewords and bursts walk from the aligned doubleword start
    new_tn.addr = (req_size_i == SIZE_DW || req_burst_i) ?
                  {req_addr_i[0:28], DW_LOW_ZERO} : req_addr_i;
    new_tn.size = req_size_i;
    new_tn.burst = req_burst_i;
    new_tn.write = req_write_i;
    new_tn.port = req_port_i;
    new_tn.tgt = req_tgt_i;
    new_tn.mach = req_mach_i;
    new_tn.ext = req_ext_i;
    // Internal slaves and page hits answer data before the address ack
    new_tn.early = (req_tgt_i == TGT_INTERNAL) ||
                   (req_mach_i == MACH_SDRAM && req_page_hit_i);
    new_tn.err = (req_tgt_i == TGT_NONE) || (req_ext_i && req_burst_i &&
                 (req_tgt_i == TGT_INTERNAL || req_tgt_i == TGT_LOCAL));
  end

  // Data tenure: walks beats of the head tenure
  always_comb begin
    d_next = d_reg;
    cur_next = cur_reg;
    rem_next = rem_reg;
    pop = 1'b0;
    we_next = LANES_OFF;
    dqm_next = LANES_OFF;
    bs_next = LANES_OFF;
    psd_next = 1'b1;
    ta_next = 1'b1;
    tea_next = 1'b1;
    doe_next = 1'b0;
    dout_next = dout_reg;
    rdata_next = rdata_reg;
    bank_next = bank_reg;
    bla_next = bla_reg;
    lb_next = 1'b0;
    snp_next = 1'b0;
    beat_next = 1'b0;
    unique case (d_reg)
      D_IDLE: begin
        // Start the oldest tenure, bursts fetch a whole line
        if (qcnt_reg != 2'h0) begin
          cur_next = q0_reg.addr;
          rem_next = q0_reg.burst ? BURST_BYTES : 6'(4'h1 << q0_reg.size);
          d_next = q0_reg.err ? D_ERR : D_BEAT;
        end
      end
      D_BEAT: begin
        // Strobes only on lanes this beat really uses
        if (q0_reg.mach == MACH_SDRAM) begin
          dqm_next = ~lane_bus.lanes;
          bank_next = cur_reg[BANK_POS +: 2];
        end else if (q0_reg.write) begin
          we_next = ~lane_bus.lanes;
        end
        if (q0_reg.mach == MACH_PROG) begin
          bs_next = ~lane_bus.lanes;
        end
        psd_next = 1'b0;
        ta_next = cfg_no_ta_i && q0_reg.tgt == TGT_BANK;
        doe_next = q0_reg.write;
        // Move bytes between their doubleword lanes and the port lanes
        dout_next = req_wdata_i << {lane_bus.shift, 3'h0};
        rdata_next = din_s2_reg >> {lane_bus.shift, 3'h0};
        beat_next = 1'b1;
        if (!cfg_single_i) begin
          bla_next = cur_reg[27:31];
        end
        lb_next = q0_reg.burst && !q0_reg.ext && q0_reg.tgt == TGT_LOCAL;
        // Core watches bridged writes to internal space, never local bus
        snp_next = q0_reg.ext && q0_reg.write && q0_reg.tgt == TGT_INTERNAL;
        cur_next = cur_reg + 32'(nb);
        rem_next = rem_reg - 6'(nb);
        if (rem_reg == 6'(nb)) begin
          pop = 1'b1;
          d_next = D_IDLE;
        end else if (q0_reg.mach == MACH_GP) begin
          d_next = D_GAP;
        end
      end
      D_GAP: begin
        // General purpose machine runs beats as single accesses
        d_next = D_BEAT;
      end
      D_ERR: begin
        tea_next = 1'b0;
        pop = 1'b1;
        d_next = D_IDLE;
      end
      default: begin
        d_next = D_IDLE;
      end
    endcase
  end

  // Address tenure, queue and address pins
  always_comb begin
    a_next = a_reg;
    tn_next = tn_reg;
    lag_next = lag_reg;
    aack_next = 1'b1;
    addr_next = addr_reg;
    aoe_next = aoe_reg;
    take = ready_reg && req_valid_i && a_reg == A_IDLE;
    push = 1'b0;
    push_tn = tn_reg;
    unique case (a_reg)
      A_IDLE: begin
        if (take) begin
          tn_next = new_tn;
          lag_next = 1'b0;
          push = new_tn.early;
          push_tn = new_tn;
          a_next = new_tn.early ? A_LAG : A_DRIVE;
          // Doublewords drive the low three pins low
          addr_next = (req_size_i == SIZE_DW || req_burst_i) ?
                      {req_addr_i[0:28], DW_LOW_ZERO} : req_addr_i;
          aoe_next = 1'b1;
        end
      end
      A_LAG: begin
        // Hold the ack back two cycles so data can lead
        lag_next = 1'b1;
        if (lag_reg) begin
          a_next = A_DRIVE;
        end
      end
      A_DRIVE: begin
        push = !tn_reg.early;
        aack_next = tn_reg.tgt == TGT_NONE;
        a_next = A_IDLE;
        // Compatible mode frees the pins; start address only
        aoe_next = cfg_single_i;
      end
      default: begin
        a_next = A_IDLE;
      end
    endcase
    // Single mode steps the real pins; SDRAM may show the row form
    if (!take && d_reg == D_BEAT && cfg_single_i) begin
      addr_next = (q0_reg.mach == MACH_SDRAM && !cfg_eav_i) ?
                  (cur_reg >> ROW_SHIFT) : cur_reg;
    end
    q0_next = q0_reg;
    q1_next = q1_reg;
    if (pop) begin
      q0_next = q1_reg;
    end
    if (push) begin
      if (qcnt_reg == 2'h0 || (qcnt_reg == 2'h1 && pop)) begin
        q0_next = push_tn;
      end else begin
        q1_next = push_tn;
      end
    end
    qcnt_next = qcnt_reg + {1'b0, push} - {1'b0, pop};
    // Bus goes to others only when idle and not in single mode
    gnt_next = !cfg_single_i && br_s2_reg && a_next == A_IDLE &&
               qcnt_next == 2'h0 && !req_valid_i;
    ready_next = a_next == A_IDLE && qcnt_next < PEND_MAX && !gnt_next;
  end

  // Registers for all groups
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      a_reg <= A_IDLE;
      d_reg <= D_IDLE;
      tn_reg <= '0;
      q0_reg <= '0;
      q1_reg <= '0;
      qcnt_reg <= 2'h0;
      lag_reg <= 1'b0;
      cur_reg <= '0;
      rem_reg <= 6'h00;
      br_s1_reg <= 1'b1;
      br_s2_reg <= 1'b0; // Second stage is active high: no request
      din_s1_reg <= '0;
      din_s2_reg <= '0;
      ready_reg <= 1'b0;
      aoe_reg <= 1'b0;
      doe_reg <= 1'b0;
      addr_reg <= '0;
      bla_reg <= '0;
      dout_reg <= '0;
      rdata_reg <= '0;
      we_reg <= LANES_OFF;
      dqm_reg <= LANES_OFF;
      bs_reg <= LANES_OFF;
      psd_reg <= 1'b1;
      aack_reg <= 1'b1;
      ta_reg <= 1'b1;
      tea_reg <= 1'b1;
      bank_reg <= '0;
      gnt_reg <= 1'b1;
      lb_reg <= 1'b0;
      snp_reg <= 1'b0;
      beat_reg <= 1'b0;
    end else begin
      a_reg <= a_next;
      d_reg <= d_next;
      tn_reg <= tn_next;
      q0_reg <= q0_next;
      q1_reg <= q1_next;
      qcnt_reg <= qcnt_next;
      lag_reg <= lag_next;
      cur_reg <= cur_next;
      rem_reg <= rem_next;
      br_s1_reg <= bus_req_n_pin_i;
      br_s2_reg <= !br_s1_reg;
      din_s1_reg <= data_pin_i;
      din_s2_reg <= din_s1_reg;
      ready_reg <= ready_next;
      aoe_reg <= aoe_next;
      doe_reg <= doe_next;
      addr_reg <= addr_next;
      bla_reg <= bla_next;
      dout_reg <= dout_next;
      rdata_reg <= rdata_next;
      we_reg <= we_next;
      dqm_reg <= dqm_next;
      bs_reg <= bs_next;
      psd_reg <= psd_next;
      aack_reg <= aack_next;
      ta_reg <= ta_next;
      tea_reg <= tea_next;
      bank_reg <= bank_next;
      gnt_reg <= !gnt_next;
      lb_reg <= lb_next;
      snp_reg <= snp_next;
      beat_reg <= beat_next;
    end
  end

  assign req_ready_o = ready_reg;
  assign addr_o = addr_reg;
  assign addr_oe_o = aoe_reg;
  assign burst_low_address_o = bla_reg;
  assign data_o = dout_reg;
  assign data_oe_o = doe_reg;
  assign lane_write_strobe_n_o = we_reg;
  assign sdram_lane_mask_o = dqm_reg;
  assign lane_byte_select_n_o = bs_reg;
  assign partial_data_valid_strobe_n_o = psd_reg;
  assign aack_n_o = aack_reg;
  assign ta_n_o = ta_reg;
  assign tea_n_o = tea_reg;
  assign sdram_bank_select_o = bank_reg;
  assign bus_grant_n_o = gnt_reg;
  assign local_burst_o = lb_reg;
  assign core_snoop_o = snp_reg;
  assign rsp_beat_o = beat_reg;
  assign rsp_rdata_o = rdata_reg;

  // Checks on the engine
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  logic quiet;
  assign quiet = qcnt_reg == 2'h0 && d_reg == D_IDLE;
  addr_dw_zero_a: assert property (take && (req_size_i == SIZE_DW || req_burst_i)
    |=> addr_o[29:31] == 3'h0) else $error("doubleword low pins not zero");
  pend_limit_a: assert property (qcnt_reg == PEND_MAX |-> !take)
    else $error("third tenure accepted");
  early_ta_a: assert property (take && new_tn.early && !new_tn.err && quiet
    |-> ##3 !ta_n_o ##1 !aack_n_o) else $error("early ack order wrong");
  bank_aack_a: assert property (take && !new_tn.early && req_tgt_i == TGT_BANK
    |-> ##2 !aack_n_o) else $error("bank hit not acknowledged");
  burst_tea_a: assert property (take && req_ext_i && req_burst_i &&
    req_tgt_i == TGT_LOCAL && quiet |-> ##4 !tea_n_o) else $error("no error ack");
  lane_quiet_a: assert property (lane_write_strobe_n_o != LANES_OFF
    |-> !partial_data_valid_strobe_n_o) else $error("strobe outside beat");
  partial_data_valid_strobe_beat_a: assert property (rsp_beat_o |-> !partial_data_valid_strobe_n_o)
    else $error("beat without partial valid");
  grant_single_a: assert property (cfg_single_i |=> bus_grant_n_o)
    else $error("bus granted in single mode");
  snoop_local_a: assert property (d_reg == D_BEAT && q0_reg.tgt == TGT_LOCAL
    |=> !core_snoop_o) else $error("local access snooped");
  burst_pins_a: assert property (d_reg == D_BEAT && !cfg_single_i
    |=> burst_low_address_o == $past(cur_reg[27:31])) else $error("burst pins stale");
  single_hold_a: assert property (cfg_single_i && aoe_reg && !take &&
    d_reg == D_IDLE |=> $stable(addr_o) && addr_oe_o) else $error("address not held");
  two_pend_c: cover property (qcnt_reg == PEND_MAX);
  early_c: cover property (!ta_n_o ##1 !aack_n_o);
  narrow_burst_c: cover property (d_reg == D_BEAT && q0_reg.burst && q0_reg.port == PORT8);
  tea_c: cover property (!tea_n_o);
endmodule

// [tb/sbl_mem_model.sv]
// Far side of the system bus: one memory on the data pins, no other master.
// Assumes the bench says when the memory is selected for a read.
`timescale 1ns/1ns
module sbl_mem_model (
  input wire logic mclk_i,
  input wire logic drive_i,
  input wire logic [0:63] word_i,
  output logic [0:63] data_pin_o,
  output logic bus_req_n_o
);
  logic [0:63] junk_reg; // Idle pattern, toggles every cycle
  logic [0:63] junk_next;

  initial junk_reg = 64'h5a5a_5a5a_5a5a_5a5a;

  // Released bus shows changing junk, so a stale value can never match
  always_comb begin
    junk_next = ~junk_reg;
  end

  always_ff @(posedge mclk_i) begin
    junk_reg <= junk_next;
  end

  // Selected memory answers on every lane
  assign data_pin_o = drive_i ? word_i : junk_reg;
  // Request pin pulled up: no foreign master competes
  assign bus_req_n_o = 1'b1;
endmodule

// [tb/tb.sv]
// Self-checking bench for the system bus lane and address engine.
// Assumes the design's timing as handed over; inputs move on falling edges.
`timescale 1ns/1ns
module tb;
  logic mclk_i, rst_n_i, req_valid_i, req_burst_i, req_write_i, req_ext_i, mem_drive;
  logic [0:31] req_addr_i;
  logic [1:0] req_size_i;
  sbl_pkg::sbl_port_t req_port_i;
  sbl_pkg::sbl_tgt_t req_tgt_i;
  sbl_pkg::sbl_mach_t req_mach_i;
  logic [0:63] data_pin_i, data_o, rsp_rdata_o;
  logic [0:31] addr_o;
  logic [27:31] burst_low_address_o;
  logic [0:7] lane_write_strobe_n_o, sdram_lane_mask_o, lane_byte_select_n_o;
  logic [0:1] sdram_bank_select_o;
  logic req_ready_o, addr_oe_o, data_oe_o, partial_data_valid_strobe_n_o;
  logic aack_n_o, ta_n_o, tea_n_o, bus_grant_n_o, local_burst_o, core_snoop_o;
  logic rsp_beat_o, bus_req_n;
  int bad_count, n_compared;
  // What one tenure showed: cycle numbers after the take edge, first beat values
  int aack_at, ta_at, tea_at, beat_at;
  logic [0:31] addr_seen;
  logic [0:7] strb_seen;
  logic [0:63] dat_seen, rdat_seen;
  logic psd_seen;
  localparam logic [0:63] WDATA = 64'h0011_2233_4455_6677; // Lane n holds byte 0xnn
  localparam logic [0:63] MEMWORD = 64'hfedc_ba98_7654_3210;

  sbl_system_bus_lanes sbl_system_bus_lanes_inst (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i), .req_addr_i(req_addr_i),
    .req_size_i(req_size_i), .req_burst_i(req_burst_i), .req_write_i(req_write_i),
    .req_port_i(req_port_i), .req_tgt_i(req_tgt_i), .req_mach_i(req_mach_i),
    .req_page_hit_i(1'b0), .req_ext_i(req_ext_i), .req_wdata_i(WDATA),
    .cfg_single_i(1'b0), .cfg_eav_i(1'b0), .cfg_no_ta_i(1'b0),
    .bus_req_n_pin_i(bus_req_n), .data_pin_i(data_pin_i), .req_ready_o(req_ready_o),
    .addr_o(addr_o), .addr_oe_o(addr_oe_o), .burst_low_address_o(burst_low_address_o),
    .data_o(data_o), .data_oe_o(data_oe_o), .lane_write_strobe_n_o(lane_write_strobe_n_o),
    .sdram_lane_mask_o(sdram_lane_mask_o), .lane_byte_select_n_o(lane_byte_select_n_o),
    .partial_data_valid_strobe_n_o(partial_data_valid_strobe_n_o), .aack_n_o(aack_n_o),
    .ta_n_o(ta_n_o), .tea_n_o(tea_n_o), .sdram_bank_select_o(sdram_bank_select_o),
    .bus_grant_n_o(bus_grant_n_o), .local_burst_o(local_burst_o),
    .core_snoop_o(core_snoop_o), .rsp_beat_o(rsp_beat_o), .rsp_rdata_o(rsp_rdata_o)
  );

  sbl_mem_model sbl_mem_model_inst (
    .mclk_i(mclk_i), .drive_i(mem_drive), .word_i(MEMWORD),
    .data_pin_o(data_pin_i), .bus_req_n_o(bus_req_n)
  );

  // 100 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // Compare one value, count it, report a difference
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One tenure: offer, wait for the take, then watch 24 cycles
  task automatic run_req(input logic [0:31] a, input logic [1:0] sz, input logic bu,
    input logic wr, input sbl_pkg::sbl_port_t pt, input sbl_pkg::sbl_tgt_t tg,
    input logic ex);
    int n;
    n = 0;
    aack_at = 0; ta_at = 0; tea_at = 0; beat_at = 0;
    @(negedge mclk_i);
    req_valid_i = 1'b1; req_addr_i = a; req_size_i = sz; req_burst_i = bu;
    req_write_i = wr; req_port_i = pt; req_tgt_i = tg; req_ext_i = ex;
    @(posedge mclk_i);
    // Bounded wait for the take edge
    while (req_ready_o !== 1'b1 && n < 50) begin
      @(posedge mclk_i);
      n++;
    end
    if (n >= 50) check("take", 1'b0, 1'b1);
    @(negedge mclk_i);
    req_valid_i = 1'b0;
    // Sample at the falling edge before rising edge n: values the design showed there
    for (n = 1; n <= 24; n++) begin
      if (n == 1) addr_seen = addr_o;
      if (aack_n_o === 1'b0 && aack_at == 0) aack_at = n;
      if (ta_n_o === 1'b0 && ta_at == 0) ta_at = n;
      if (tea_n_o === 1'b0 && tea_at == 0) tea_at = n;
      if (rsp_beat_o === 1'b1 && beat_at == 0) begin
        beat_at = n;
        strb_seen = lane_write_strobe_n_o;
        dat_seen = data_o;
        rdat_seen = rsp_rdata_o;
        psd_seen = partial_data_valid_strobe_n_o;
      end
      @(negedge mclk_i);
    end
  endtask

  // Misaligned doubleword write to a bank: low pins forced, all lanes strobed
  task automatic t_dw_write();
    run_req(32'h1234_567c, sbl_pkg::SIZE_DW, 1'b0, 1'b1, sbl_pkg::PORT64,
      sbl_pkg::TGT_BANK, 1'b0);
    check("dw addr", addr_seen, 32'h1234_5678);
    check("dw aack", aack_at, 2);
    check("dw ta", ta_at, 4);
    check("dw partial_data_valid_strobe", psd_seen, 1'b0);
    check("dw strobes", strb_seen, 8'h00);
    check("dw data", dat_seen, WDATA);
    check("dw grant", bus_grant_n_o, 1'b1);
    $display("test dw_write done");
  endtask

  // Single byte at offset 5 of an 8-bit port: moved to lane 0 alone
  task automatic t_byte_write();
    run_req(32'h0000_0105, 2'h0, 1'b0, 1'b1, sbl_pkg::PORT8, sbl_pkg::TGT_BANK, 1'b0);
    check("byte addr", addr_seen, 32'h0000_0105);
    check("byte strobes", strb_seen, 8'h7f);
    check("byte lane0", dat_seen[0:7], 8'h55);
    check("byte partial_data_valid_strobe", psd_seen, 1'b0);
    $display("test byte_write done");
  endtask

  // Doubleword read from a 64-bit bank: pin order kept end to end
  task automatic t_dw_read();
    mem_drive = 1'b1;
    run_req(32'h0000_2000, sbl_pkg::SIZE_DW, 1'b0, 1'b0, sbl_pkg::PORT64,
      sbl_pkg::TGT_BANK, 1'b0);
    mem_drive = 1'b0;
    check("rd data", rdat_seen, MEMWORD);
    check("rd aack", aack_at, 2);
    $display("test dw_read done");
  endtask

  // Internal slave: transfer acknowledge ahead of address acknowledge
  task automatic t_early();
    run_req(32'h0000_3000, sbl_pkg::SIZE_DW, 1'b0, 1'b1, sbl_pkg::PORT64,
      sbl_pkg::TGT_INTERNAL, 1'b0);
    check("early ta", ta_at, 3);
    check("early aack", aack_at, 4);
    $display("test early done");
  endtask

  // Foreign burst into local space errors; unowned space gets no aack
  task automatic t_errors();
    run_req(32'h0000_4000, sbl_pkg::SIZE_DW, 1'b1, 1'b0, sbl_pkg::PORT64,
      sbl_pkg::TGT_LOCAL, 1'b1);
    check("burst tea", tea_at, 4);
    check("burst beat", beat_at, 0);
    run_req(32'h0000_5000, sbl_pkg::SIZE_DW, 1'b0, 1'b0, sbl_pkg::PORT64,
      sbl_pkg::TGT_NONE, 1'b0);
    check("none aack", aack_at, 0);
    check("none tea", tea_at > 0, 1'b1);
    $display("test errors done");
  endtask

  // Watchdog well past the expected run of under two hundred cycles
  initial begin
    #200000;
    bad_count++;
    results();
  end

  // Main sequence
  initial begin
    bad_count = 0; n_compared = 0; mem_drive = 1'b0;
    rst_n_i = 1'b0; req_valid_i = 1'b0; req_addr_i = 32'h0000_0000; req_size_i = 2'h0;
    req_burst_i = 1'b0; req_write_i = 1'b0; req_ext_i = 1'b0;
    req_port_i = sbl_pkg::PORT64; req_tgt_i = sbl_pkg::TGT_NONE; req_mach_i = sbl_pkg::MACH_GP;
    repeat (20) @(negedge mclk_i);
    rst_n_i = 1'b1;
    t_dw_write();
    t_byte_write();
    t_dw_read();
    t_early();
    t_errors();
    results();
  end
endmodule
